// ===== verilog/dac_load_regs.svh
// Constants for the serial converter load front end
`ifndef DAC_LOAD_REGS_SVH
`define DAC_LOAD_REGS_SVH

// Converter word width and its zero-scale code
`define DAC_WORD_BITS 16
`define DAC_ZERO_CODE 16'h0000

// Bit counter width and its saturation value
`define DAC_CNT_BITS 5
`define DAC_CNT_MAX 5'h1f
`define DAC_CNT_FULL 5'h10
`define DAC_CNT_ZERO 5'h00

// Pin bundle: positions inside the synchroniser vector
`define PIN_FRAME 0
`define PIN_SCLK 1
`define PIN_DATA 2
`define PIN_LOAD 3
`define PIN_CLEAR 4
`define PIN_COUNT 5
// Idle levels: frame, load and clear high, clock and data low
`define PIN_IDLE 5'h19

`endif

// ===== verilog/dac_load_pkg.sv
// Types shared by the serial converter load front end
package dac_load_pkg;
`include "dac_load_regs.svh"

    typedef logic [`DAC_WORD_BITS-1:0] word_t;
    typedef logic [`DAC_CNT_BITS-1:0] bit_cnt_t;
    typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} link_state_t;

endpackage

// ===== verilog/link_if.sv
// Synchronised pin levels and edge pulses from sampler to core
interface link_if;
    logic frame_n;
    logic data;
    logic load_n;
    logic clear_n;
    logic sclk_rise;
    logic frame_start;
    logic frame_end;
    logic load_fall;
    logic clear_fall;

    modport sampler (
        output frame_n, data, load_n, clear_n,
        output sclk_rise, frame_start, frame_end, load_fall, clear_fall
    );
    modport core (
        input frame_n, data, load_n, clear_n,
        input sclk_rise, frame_start, frame_end, load_fall, clear_fall
    );
endinterface

// ===== verilog/pin_sampler.sv
// Two-stage synchronisers and edge detection for the link pins
`include "dac_load_regs.svh"
module pin_sampler
    import dac_load_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [`PIN_COUNT-1:0] pins_in,
    link_if.sampler lnk
);
    // ******************************************************
    // Synchronisers
    // ******************************************************
    logic [`PIN_COUNT-1:0] meta_q;
    logic [`PIN_COUNT-1:0] sync_q;
    logic [`PIN_COUNT-1:0] prev_q;
    logic [`PIN_COUNT-1:0] meta_d;
    logic [`PIN_COUNT-1:0] sync_d;
    logic [`PIN_COUNT-1:0] prev_d;

    // Edges are found on the second stage only, never the first
    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_sync
            always_comb begin
                meta_d[gi] = pins_in[gi];
                sync_d[gi] = meta_q[gi];
                prev_d[gi] = sync_q[gi];
            end
        end
    endgenerate

    // Idle levels at reset so no false edge appears on release
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= `PIN_IDLE;
            sync_q <= `PIN_IDLE;
            prev_q <= `PIN_IDLE;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ******************************************************
    // Levels and edge pulses
    // ******************************************************
    assign lnk.frame_n = sync_q[`PIN_FRAME];
    assign lnk.data = sync_q[`PIN_DATA];
    assign lnk.load_n = sync_q[`PIN_LOAD];
    assign lnk.clear_n = sync_q[`PIN_CLEAR];
    assign lnk.sclk_rise = sync_q[`PIN_SCLK] & ~prev_q[`PIN_SCLK];
    assign lnk.frame_start = ~sync_q[`PIN_FRAME] & prev_q[`PIN_FRAME];
    assign lnk.frame_end = sync_q[`PIN_FRAME] & ~prev_q[`PIN_FRAME];
    assign lnk.load_fall = ~sync_q[`PIN_LOAD] & prev_q[`PIN_LOAD];
    assign lnk.clear_fall = ~sync_q[`PIN_CLEAR] & prev_q[`PIN_CLEAR];
endmodule

// ===== verilog/serial_dac_input_load.sv
// Serial input register and converter register of a 16-bit converter
`include "dac_load_regs.svh"
// Overview of operation
// - Serial bits are accepted only inside a frame, frame select low.
// - Data is shifted in on each rising serial clock edge.
// - Words are sixteen bits; the serial input register holds sixteen bits.
// - A falling load strobe copies the serial register into the converter register.
// - The clear input acts on its falling edge, independent of serial clock.
// - While clear is low, load strobes are ignored.
// - Clear sets both serial and converter registers to zero scale.
// - Words shift most significant bit first.
// - Frame end after sixteen bits loads the converter when strobe is low.
// - Clock and data toggles outside a frame have no effect.
// - Reset puts both registers at zero scale, output at zero volts.
module serial_dac_input_load
    import dac_load_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic frame_sel_n_in,
    input wire logic sclk_in,
    input wire logic sdata_in,
    input wire logic load_strobe_n_in,
    input wire logic async_clear_n_in,
    output dac_load_pkg::word_t dac_code_out,
    output dac_load_pkg::word_t input_word_out,
    output logic frame_active_out
);
    import dac_load_pkg::*;

    // ******************************************************
    // Pin sampling
    // ******************************************************
    link_if lnk ();
    logic [`PIN_COUNT-1:0] pins;

    // The serial clock is sampled, not used as a clock: 80 ns link
    // period leaves many system cycles per half period
    always_comb begin
        pins = '0;
        pins[`PIN_FRAME] = frame_sel_n_in;
        pins[`PIN_SCLK] = sclk_in;
        pins[`PIN_DATA] = sdata_in;
        pins[`PIN_LOAD] = load_strobe_n_in;
        pins[`PIN_CLEAR] = async_clear_n_in;
    end

    pin_sampler u_sampler (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .pins_in(pins),
        .lnk(lnk.sampler)
    );

    // ******************************************************
    // Link state and registers
    // ******************************************************
    link_state_t state_q;
    link_state_t state_d;
    word_t shift_q;
    word_t shift_d;
    word_t dac_q;
    word_t dac_d;
    bit_cnt_t cnt_q;
    bit_cnt_t cnt_d;
    logic load_ok;

    // Strobes count only while clear is released and not falling
    assign load_ok = lnk.clear_n & ~lnk.clear_fall;

    // Next-state logic; clear is applied last so it outranks shifts and loads,
    // while a frame that opens in the same cycle is still tracked
    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        dac_d = dac_q;
        cnt_d = cnt_q;
        if (lnk.load_fall && load_ok) begin
            dac_d = shift_q;
        end
        case (state_q)
            ST_IDLE: begin
                // Toggles outside a frame are simply dropped
                if (lnk.frame_start) begin
                    state_d = ST_SHIFT;
                    cnt_d = `DAC_CNT_ZERO;
                end
            end
            ST_SHIFT: begin
                if (lnk.frame_end) begin
                    state_d = ST_IDLE;
                    // Short or long frames do not load the converter at frame end
                    if (cnt_q == `DAC_CNT_FULL && !lnk.load_n && load_ok) begin
                        dac_d = shift_q;
                    end
                end else if (lnk.sclk_rise && !lnk.frame_n) begin
                    // Extra bits push out the oldest, keeping the last 16
                    shift_d = {shift_q[`DAC_WORD_BITS-2:0], lnk.data};
                    if (cnt_q != `DAC_CNT_MAX) begin
                        cnt_d = bit_cnt_t'(cnt_q + 5'h01);
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // Clear zeroes both registers whatever else happens this cycle
        if (lnk.clear_fall) begin
            shift_d = `DAC_ZERO_CODE;
            dac_d = `DAC_ZERO_CODE;
        end
    end

    // Registers only; zero scale after reset puts the output at 0 V
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            shift_q <= `DAC_ZERO_CODE;
            dac_q <= `DAC_ZERO_CODE;
            cnt_q <= `DAC_CNT_ZERO;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            dac_q <= dac_d;
            cnt_q <= cnt_d;
        end
    end

    // ******************************************************
    // Outputs
    // ******************************************************
    // All outputs come straight from flip-flops
    assign dac_code_out = dac_q;
    assign input_word_out = shift_q;
    assign frame_active_out = (state_q == ST_SHIFT);

    // ******************************************************
    // Checks
    // ******************************************************
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // Frame opening: start edge then counting from zero
    sequence frame_open_s;
        state_q == ST_IDLE && lnk.frame_start && !lnk.clear_fall;
    endsequence
    sequence counting_s;
        state_q == ST_SHIFT && cnt_q == `DAC_CNT_ZERO;
    endsequence

    // Complete frame closing with the strobe low
    sequence full_close_s;
        state_q == ST_SHIFT && lnk.frame_end && cnt_q == `DAC_CNT_FULL
            && !lnk.load_n && load_ok;
    endsequence

    AST_FRAME_OPENS: assert property (frame_open_s |=> counting_s)
        else $error("Frame start did not open a counting frame");

    AST_SHIFT_MSB_FIRST: assert property (
        state_q == ST_SHIFT && lnk.sclk_rise && !lnk.frame_n && !lnk.frame_end
            && !lnk.clear_fall
        |=> shift_q == {$past(shift_q[`DAC_WORD_BITS-2:0]), $past(lnk.data)})
        else $error("Serial bit not shifted in at the low end");

    AST_IDLE_NO_SHIFT: assert property (
        state_q == ST_IDLE && !lnk.clear_fall |=> $stable(shift_q))
        else $error("Serial register changed outside a frame");

    AST_LOAD_COPIES: assert property (
        lnk.load_fall && load_ok |=> dac_q == $past(shift_q))
        else $error("Load strobe did not copy the serial register");

    AST_CLEAR_ZERO: assert property (
        lnk.clear_fall |=> shift_q == `DAC_ZERO_CODE && dac_q == `DAC_ZERO_CODE)
        else $error("Clear did not zero both registers");

    AST_CLEAR_BLOCKS_LOAD: assert property (
        !lnk.clear_n && !lnk.clear_fall |=> $stable(dac_q))
        else $error("Converter register changed while clear held low");

    AST_FRAME_LOADS: assert property (
        full_close_s |=> dac_q == $past(shift_q) && state_q == ST_IDLE)
        else $error("Full frame with strobe low did not load converter");

    AST_FRAME_HOLDS: assert property (
        lnk.frame_end && lnk.load_n && !lnk.load_fall && !lnk.clear_fall
        |=> $stable(dac_q))
        else $error("Frame end with strobe high changed converter");

    AST_SHORT_FRAME: assert property (
        state_q == ST_SHIFT && lnk.frame_end && cnt_q != `DAC_CNT_FULL
            && !lnk.load_fall && !lnk.clear_fall
        |=> $stable(dac_q) && $stable(shift_q))
        else $error("Wrong-length frame disturbed the registers");

    AST_COUNT_CAP: assert property (
        state_q == ST_SHIFT && cnt_q == `DAC_CNT_MAX && !lnk.frame_end
            && !lnk.clear_fall |=> cnt_q == `DAC_CNT_MAX)
        else $error("Bit counter wrapped");

    // Shifting discipline: the register moves only on a taken bit or a clear
    AST_SHIFT_ONLY_ON_EDGE: assert property (
        state_q == ST_SHIFT && !(lnk.sclk_rise && !lnk.frame_n) && !lnk.clear_fall
        |=> $stable(shift_q))
        else $error("Serial register moved without a serial clock edge");

    AST_COUNT_STEPS: assert property (
        state_q == ST_SHIFT && lnk.sclk_rise && !lnk.frame_n && !lnk.frame_end
            && cnt_q != `DAC_CNT_MAX
        |=> cnt_q == bit_cnt_t'($past(cnt_q) + 5'h01))
        else $error("Bit counter did not step on a taken bit");

    // Frame closing and idle behaviour
    AST_FRAME_CLOSES: assert property (
        state_q == ST_SHIFT && lnk.frame_end |=> state_q == ST_IDLE)
        else $error("Frame end did not close the frame");

    AST_IDLE_NO_LOAD: assert property (
        state_q == ST_IDLE && !lnk.load_fall && !lnk.clear_fall |=> $stable(dac_q))
        else $error("Converter register changed outside a frame");
endmodule

// ===== verif/host_link_model.sv
// Host side of the serial link: frames and shifts words into the device
module host_link_model (
    input wire logic sys_clk_in,
    output logic frame_sel_n_out,
    output logic sclk_out,
    output logic sdata_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import dac_load_pkg::*;

    // Idle link: frame high, clock parked low
    initial begin
        frame_sel_n_out = 1'b1;
        sclk_out = 1'b0;
        sdata_out = 1'b0;
    end

    // One frame of nbits bits of w, most significant first; past sixteen
    // bits the word repeats, so long frames stay deterministic
    task automatic send_word(input word_t w, input int nbits);
        frame_sel_n_out = 1'b0;
        repeat (4) @(negedge sys_clk_in);
        for (int i = 0; i < nbits; i++) begin
            sdata_out = w[4'(15 - i)];
            repeat (4) @(negedge sys_clk_in);
            sclk_out = 1'b1;
            repeat (8) @(negedge sys_clk_in);
            sclk_out = 1'b0;
            repeat (4) @(negedge sys_clk_in);
        end
        // Released data shows the inverse so stale bits cannot pass
        sdata_out = ~sdata_out;
        frame_sel_n_out = 1'b1;
        repeat (8) @(negedge sys_clk_in);
    endtask

    // Clock and data activity with no frame open
    task automatic toggle_idle();
        for (int i = 0; i < 20; i++) begin
            sdata_out = ~sdata_out;
            sclk_out = ~sclk_out;
            repeat (8) @(negedge sys_clk_in);
        end
    endtask
endmodule

// ===== verif/serial_dac_input_load_tb_top.sv
// Self-checking bench for the converter load front end
module serial_dac_input_load_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import dac_load_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_in = 1'b1;
    logic load_n = 1'b1;
    logic clear_n = 1'b1;
    logic frame_n;
    logic sclk;
    logic sdata;
    word_t dac_code;
    word_t input_word;
    logic frame_active;
    int error_cnt = 0;
    int compares = 0;

    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;

    host_link_model i_host (
        .sys_clk_in(sys_clk),
        .frame_sel_n_out(frame_n),
        .sclk_out(sclk),
        .sdata_out(sdata)
    );

    serial_dac_input_load i_dut (
        .sys_clk_in(sys_clk),
        .rst_in(rst_in),
        .frame_sel_n_in(frame_n),
        .sclk_in(sclk),
        .sdata_in(sdata),
        .load_strobe_n_in(load_n),
        .async_clear_n_in(clear_n),
        .dac_code_out(dac_code),
        .input_word_out(input_word),
        .frame_active_out(frame_active)
    );

    // Four-state comparison of a word result
    task automatic check_word(input string what, input word_t exp, input word_t got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Four-state comparison of a single flag
    task automatic check_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Pulse a control pin low long enough to be sampled
    task automatic strobe_load();
        load_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        load_n = 1'b1;
        repeat (8) @(negedge sys_clk);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic sc_frame_load();
        load_n = 1'b0;
        fork
            i_host.send_word(16'ha5c3, 16);
            begin
                repeat (12) @(negedge sys_clk);
                check_bit("frame_active", 1'b1, frame_active);
            end
        join
        check_bit("frame_active", 1'b0, frame_active);
        check_word("input_word", 16'ha5c3, input_word);
        check_word("dac_code", 16'ha5c3, dac_code);
        load_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask

    // Preload with strobe high, idle noise, then strobe
    task automatic sc_preload();
        i_host.send_word(16'h3c96, 16);
        check_word("dac_code", 16'ha5c3, dac_code);
        i_host.toggle_idle();
        check_word("input_word", 16'h3c96, input_word);
        strobe_load();
        check_word("dac_code", 16'h3c96, dac_code);
    endtask

    // Clear zeroes both; strobes while clear is low do nothing
    task automatic sc_clear();
        clear_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check_word("dac_code", 16'h0000, dac_code);
        check_word("input_word", 16'h0000, input_word);
        i_host.send_word(16'h1234, 16);
        check_word("input_word", 16'h1234, input_word);
        strobe_load();
        check_word("dac_code", 16'h0000, dac_code);
        clear_n = 1'b1;
        repeat (4) @(negedge sys_clk);
    endtask

    // A 15-bit frame must not load even with strobe low; the strobe's
    // falling edge first copies the word left from the clear scenario
    task automatic sc_short();
        load_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check_word("dac_code", 16'h1234, dac_code);
        i_host.send_word(16'hffff, 15);
        load_n = 1'b1;
        check_word("dac_code", 16'h1234, dac_code);
        check_word("input_word", 16'h7fff, input_word);
        repeat (4) @(negedge sys_clk);
    endtask

    // A 34-bit frame saturates the counter, keeps the last 16 bits, never loads
    task automatic sc_long();
        load_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        check_word("dac_code", 16'h7fff, dac_code);
        i_host.send_word(16'h8001, 34);
        load_n = 1'b1;
        check_word("dac_code", 16'h7fff, dac_code);
        check_word("input_word", 16'h0006, input_word);
        repeat (4) @(negedge sys_clk);
    endtask

    // Reset in mid-run returns both registers to zero scale, no false edges after
    task automatic sc_reset();
        rst_in = 1'b1;
        repeat (6) @(negedge sys_clk);
        check_word("dac_code", 16'h0000, dac_code);
        check_word("input_word", 16'h0000, input_word);
        check_bit("frame_active", 1'b0, frame_active);
        rst_in = 1'b0;
        repeat (4) @(negedge sys_clk);
        check_word("dac_code", 16'h0000, dac_code);
    endtask

    // Watchdog well past the expected run length
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(negedge sys_clk);
        rst_in = 1'b0;
        repeat (2) @(negedge sys_clk);
        check_word("dac_code", 16'h0000, dac_code);
        check_word("input_word", 16'h0000, input_word);
        sc_frame_load();
        sc_preload();
        sc_clear();
        sc_short();
        sc_long();
        sc_reset();
        tally_and_finish();
    end
endmodule
